//--- rtl/mdmap_pkg.sv
package mdmap_pkg;
  // ****************
  // Register map
  // ****************
  localparam logic [7:0] OFF_POLL = 8'h00;
  localparam logic [7:0] OFF_SPEED = 8'h04;
  localparam logic [7:0] OFF_PADDR = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_WDATA = 8'h14;
  localparam logic [7:0] OFF_STAT_LO = 8'h18;
  localparam logic [7:0] OFF_STAT_HI = 8'h1C;
  localparam int CMD_BUSY_BIT = 15;
  localparam int CMD_KIND_LSB = 10;
  localparam int CMD_DEV_LSB = 5;
  localparam int POLL_GAP_LSB = 8;
  localparam int NPORT = 6;
  localparam logic [5:0] POLL_EN_RST = 6'h3F;
  localparam logic [7:0] POLL_GAP_RST = 8'h10;
  localparam logic [29:0] PADDR_RST = {5'd5, 5'd4, 5'd3, 5'd2, 5'd1, 5'd0};
  // ****************
  // Timing
  // ****************
  localparam longint CLK_HZ = 25_000_000;
  localparam longint MDC_DEF_HZ = 3_400_000;
  localparam longint MDC_MAX_HZ = 17_000_000;
  // Half period of the management clock in core cycles, rounded up
  localparam logic [7:0] MDC_HALF_RST = 8'((CLK_HZ + 2 * MDC_DEF_HZ - 1) / (2 * MDC_DEF_HZ));
  localparam logic [7:0] MDC_HALF_MIN = 8'((CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ));
  // ****************
  // Frame layout
  // ****************
  localparam logic [5:0] FRAME_LAST = 6'd63;
  localparam logic [5:0] TA_FIRST = 6'd46;
  localparam logic [5:0] DATA_FIRST = 6'd48;
  localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0] START_CODE = 2'b01;
  localparam logic [1:0] KIND_WR = 2'b01;
  localparam logic [1:0] KIND_RD = 2'b10;
  localparam logic [1:0] TA_WR = 2'b10;
  // ****************
  // PHY register indices
  // ****************
  localparam logic [4:0] R_CTRL = 5'd0;
  localparam logic [4:0] R_STAT = 5'd1;
  localparam logic [4:0] R_ADV = 5'd4;
  localparam logic [4:0] R_LPA = 5'd5;
  localparam logic [4:0] R_ANX = 5'd6;
  localparam logic [4:0] R_GCTL = 5'd9;
  localparam logic [4:0] R_GSTAT = 5'd10;
  localparam logic [4:0] R_XSTAT = 5'd15;
  localparam logic [3:0] STEP_EEE = 4'd8;
  typedef enum logic [1:0] {E_IDLE = 2'b01, E_SHIFT = 2'b10} mdmap_eng_type;
  typedef enum logic [3:0] {
    P_NEXT = 4'b0001, P_REQ = 4'b0010, P_WAIT = 4'b0100, P_GAP = 4'b1000
  } mdmap_poll_type;
  typedef struct packed {
    logic inactive;
    logic eee;
    logic [1:0] pause;
    logic duplex;
    logic [1:0] speed;
    logic link;
  } mdmap_stat_type;
  typedef struct packed {
    logic [5:0] poll_en;
    logic [7:0] gap;
    logic [7:0] half;
    logic [29:0] paddr;
    logic busy;
    logic cmd_run;
    logic [1:0] kind;
    logic [4:0] dev;
    logic [4:0] regi;
    logic [15:0] rdata;
    logic [15:0] wdata;
    mdmap_stat_type [5:0] stat;
    logic [31:0] prdata;
    logic slverr;
    mdmap_eng_type eng;
    logic own_cmd;
    logic rd;
    logic [7:0] div;
    logic mdc;
    logic [5:0] bitn;
    logic [63:0] frame;
    logic mdio_o;
    logic oe_n;
    logic [15:0] shin;
    logic done;
    logic m1;
    logic m2;
    mdmap_poll_type ps;
    logic [2:0] port;
    logic [3:0] step;
    logic [15:0] gapc;
    logic [8:0][15:0] pr;
  } mdmap_state_type;
endpackage

//--- rtl/mdmap_master.sv
// Operation
// - Frames use clause 22 format: preamble, start, kind, addresses, turnaround, data.
// - Each frame carries a 5-bit device address, one of 32 devices.
// - Each frame carries a 5-bit register index and one 16-bit word.
// - Management clock defaults to 3.125 MHz, programmable up to 12.5 MHz.
// - Six ports with programmable PHY addresses, defaults 0 through 5.
// - Writing the command register launches a frame to the named device.
// - Polling reads PHY status of enabled ports and sets the MAC status.
// - Indirect commands win over the polling machine for the link.
// - Unpolled ports keep last status, and software may overwrite it.
// - Poller visits enabled ports in order, waits a gap, repeats forever.
// - Control register read first; all ones reports the PHY inactive.
// - Without negotiation take speed/duplex from control, link from status, full pause.
// - Negotiation incomplete ends the pass with link reported zero.
// - Extended status bit set means gigabit PHY, else fast Ethernet.
// - Fast Ethernet PHY: fetch partner and local ability registers.
// - Gigabit PHY: also fetch gigabit partner, local and extended status.
// - Without next page received, gigabit PHY resolves from abilities only.
// - After the EEE fetch, resolve everything and report it to the MAC.
// - Indirect path does single transactions only, no bursts.
`timescale 1ns/1ps
`default_nettype none
module mdmap_master #(
  parameter logic [15:0] GAP_UNIT = 16'd256,
  parameter logic [4:0] EEE_REG = 5'd16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Management link
  output logic mdc,
  output logic mdio_o,
  output logic mdio_oe_n,
  input wire logic mdio_i,
  // MAC status per port
  output mdmap_pkg::mdmap_stat_type [5:0] mac_status
);
  import mdmap_pkg::*;

  mdmap_state_type s_reg;
  mdmap_state_type s_next;

  // ****************
  // Helpers
  // ****************
  function automatic logic [4:0] step_reg(input logic [3:0] st);
    case (st)
      4'd0: step_reg = R_CTRL;
      4'd1: step_reg = R_STAT;
      4'd2: step_reg = R_ADV;
      4'd3: step_reg = R_LPA;
      4'd4: step_reg = R_ANX;
      4'd5: step_reg = R_GCTL;
      4'd6: step_reg = R_GSTAT;
      4'd7: step_reg = R_XSTAT;
      default: step_reg = EEE_REG;
    endcase
  endfunction

  function automatic logic [63:0] build_frame(input logic [1:0] kind, input logic [4:0] dev,
                                              input logic [4:0] regi, input logic [15:0] wd);
    build_frame = {PREAMBLE, START_CODE, kind, dev, regi,
                   (kind == KIND_WR) ? {TA_WR, wd} : 18'h3_FFFF};
  endfunction

  // Auto resolution over fetched registers
  function automatic mdmap_stat_type resolve(input logic [8:0][15:0] pr, input logic [15:0] ee);
    logic [15:0] ab;
    mdmap_stat_type r;
    ab = pr[2] & pr[3];
    r = '0;
    r.link = pr[1][2];
    r.eee = ee[0];
    r.pause = {pr[2][10] & pr[3][10], pr[2][11] & pr[3][11]};
    if (pr[1][8] && pr[4][1] && (|pr[7][15:12]) && pr[5][9] && pr[6][11]) begin
      r.speed = 2'b10;
      r.duplex = 1'b1;
    end else if (pr[1][8] && pr[4][1] && (|pr[7][15:12]) && pr[5][8] && pr[6][10]) begin
      r.speed = 2'b10;
    end else if (ab[8]) begin
      r.speed = 2'b01;
      r.duplex = 1'b1;
    end else if (ab[7]) begin
      r.speed = 2'b01;
    end else begin
      r.duplex = ab[6];
    end
    return r;
  endfunction

  function automatic logic [31:0] pack_stat(input mdmap_stat_type a, input mdmap_stat_type b,
                                            input mdmap_stat_type c, input mdmap_stat_type d);
    pack_stat = {d, c, b, a};
  endfunction

  // ****************
  // Next state
  // ****************
  always_comb begin
    logic acc;
    logic wr;
    logic tick;
    logic fin;
    mdmap_stat_type st;
    logic [15:0] v;
    acc = 1'b0;
    wr = 1'b0;
    tick = 1'b0;
    fin = 1'b0;
    st = '0;
    v = s_reg.shin;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.m1 = mdio_i;
    s_next.m2 = s_reg.m1;

    // ****************
    // APB slave
    // ****************
    acc = psel && !penable;
    wr = psel && penable && pwrite;
    if (acc) begin
      s_next.slverr = 1'b0;
      case (paddr)
        OFF_POLL: s_next.prdata = {16'h0000, s_reg.gap, 2'b00, s_reg.poll_en};
        OFF_SPEED: s_next.prdata = {24'h00_0000, s_reg.half};
        OFF_PADDR: s_next.prdata = {2'b00, s_reg.paddr};
        OFF_CMD: s_next.prdata = {16'h0000, s_reg.busy, 3'b000, s_reg.kind, s_reg.dev, s_reg.regi};
        OFF_RDATA: s_next.prdata = {16'h0000, s_reg.rdata};
        OFF_WDATA: s_next.prdata = {16'h0000, s_reg.wdata};
        OFF_STAT_LO: s_next.prdata = pack_stat(s_reg.stat[0], s_reg.stat[1], s_reg.stat[2], s_reg.stat[3]);
        OFF_STAT_HI: s_next.prdata = {16'h0000, s_reg.stat[5], s_reg.stat[4]};
        default: begin
          s_next.prdata = 32'h0000_0000;
          s_next.slverr = 1'b1;
        end
      endcase
    end
    if (wr) begin
      case (paddr)
        OFF_POLL: begin
          s_next.poll_en = pwdata[5:0];
          s_next.gap = pwdata[POLL_GAP_LSB +: 8];
        end
        OFF_SPEED: s_next.half = (pwdata[7:0] < MDC_HALF_MIN) ? MDC_HALF_MIN : pwdata[7:0];
        OFF_PADDR: s_next.paddr = pwdata[29:0];
        OFF_CMD: begin
          // A command while busy is dropped: one transaction at a time
          if (!s_reg.busy && (pwdata[11:10] == KIND_RD || pwdata[11:10] == KIND_WR)) begin
            s_next.busy = 1'b1;
            s_next.kind = pwdata[CMD_KIND_LSB +: 2];
            s_next.dev = pwdata[CMD_DEV_LSB +: 5];
            s_next.regi = pwdata[4:0];
          end
        end
        OFF_WDATA: s_next.wdata = pwdata[15:0];
        OFF_STAT_LO, OFF_STAT_HI: begin
          for (int i = 0; i < NPORT; i++) begin
            if (!s_reg.poll_en[i] && (paddr == OFF_STAT_HI) == (i >= 4)) begin
              s_next.stat[i] = pwdata[(i % 4) * 8 +: 8];
            end
          end
        end
        default: ;
      endcase
    end

    // ****************
    // Frame engine
    // ****************
    tick = (s_reg.div + 8'h01) >= s_reg.half;
    unique case (s_reg.eng)
      E_IDLE: begin
        s_next.oe_n = 1'b1;
        s_next.mdio_o = 1'b1;
        s_next.mdc = 1'b0;
        if (s_reg.busy && !s_reg.cmd_run) begin
          s_next.cmd_run = 1'b1;
          s_next.own_cmd = 1'b1;
          s_next.rd = s_reg.kind == KIND_RD;
          s_next.frame = build_frame(s_reg.kind, s_reg.dev, s_reg.regi, s_reg.wdata);
        end else if (s_reg.ps == P_REQ) begin
          s_next.own_cmd = 1'b0;
          s_next.rd = 1'b1;
          s_next.frame = build_frame(KIND_RD, s_reg.paddr[s_reg.port * 5 +: 5], step_reg(s_reg.step), 16'h0000);
          s_next.ps = P_WAIT;
        end
        if ((s_reg.busy && !s_reg.cmd_run) || s_reg.ps == P_REQ) begin
          s_next.eng = E_SHIFT;
          s_next.bitn = 6'd0;
          s_next.div = 8'h00;
          s_next.oe_n = 1'b0;
          s_next.mdio_o = s_next.frame[63];
        end
      end
      E_SHIFT: begin
        s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;
        if (tick && !s_reg.mdc) begin
          // Sample on the rising edge, data settled half a period earlier
          s_next.mdc = 1'b1;
          if (s_reg.rd && s_reg.bitn >= DATA_FIRST) begin
            s_next.shin = {s_reg.shin[14:0], s_reg.m2};
          end
        end else if (tick) begin
          s_next.mdc = 1'b0;
          if (s_reg.bitn == FRAME_LAST) begin
            s_next.eng = E_IDLE;
            s_next.done = 1'b1;
            s_next.oe_n = 1'b1;
            if (s_reg.own_cmd) begin
              if (s_reg.rd) begin
                s_next.rdata = s_next.shin;
              end
              s_next.busy = 1'b0;
              s_next.cmd_run = 1'b0;
            end
          end else begin
            s_next.bitn = s_reg.bitn + 6'd1;
            s_next.frame = {s_reg.frame[62:0], 1'b1};
            s_next.mdio_o = s_reg.frame[62];
            // Release the line at turnaround so the PHY can drive
            s_next.oe_n = s_reg.rd && (s_reg.bitn + 6'd1 >= TA_FIRST);
          end
        end
      end
    endcase

    // ****************
    // Polling machine
    // ****************
    st = s_reg.stat[s_reg.port];
    unique case (s_reg.ps)
      P_NEXT: begin
        if (s_reg.poll_en[s_reg.port]) begin
          s_next.step = 4'd0;
          s_next.ps = P_REQ;
        end else if (s_reg.port == 3'd5) begin
          s_next.port = 3'd0;
          s_next.gapc = 16'(s_reg.gap * GAP_UNIT);
          s_next.ps = P_GAP;
        end else begin
          s_next.port = s_reg.port + 3'd1;
        end
      end
      P_REQ: ;
      P_WAIT: begin
        if (s_reg.done && !s_reg.own_cmd) begin
          s_next.pr[s_reg.step] = v;
          s_next.ps = P_REQ;
          s_next.step = s_reg.step + 4'd1;
          if (s_reg.step == 4'd0 && v == 16'hFFFF) begin
            st.inactive = 1'b1;
            st.link = 1'b0;
            fin = 1'b1;
          end else if (s_reg.step == 4'd1 && !s_reg.pr[0][12]) begin
            st = '0;
            st.link = v[2];
            st.speed = {s_reg.pr[0][6], s_reg.pr[0][13]};
            st.duplex = s_reg.pr[0][8];
            st.pause = 2'b11;
            st.eee = s_reg.stat[s_reg.port].eee;
            fin = 1'b1;
          end else if (s_reg.step == 4'd1 && !v[5]) begin
            st.inactive = 1'b0;
            st.link = 1'b0;
            fin = 1'b1;
          end else if (s_reg.step == 4'd3 && !s_reg.pr[1][8]) begin
            s_next.step = STEP_EEE;
          end else if (s_reg.step == STEP_EEE) begin
            st = resolve(s_reg.pr, v);
            fin = 1'b1;
          end
        end
        if (fin) begin
          if (s_reg.poll_en[s_reg.port]) begin
            s_next.stat[s_reg.port] = st;
          end
          if (s_reg.port == 3'd5) begin
            s_next.port = 3'd0;
            s_next.gapc = 16'(s_reg.gap * GAP_UNIT);
            s_next.ps = P_GAP;
          end else begin
            s_next.port = s_reg.port + 3'd1;
            s_next.ps = P_NEXT;
          end
        end
      end
      P_GAP: begin
        if (s_reg.gapc == 16'h0000) begin
          s_next.ps = P_NEXT;
        end else begin
          s_next.gapc = s_reg.gapc - 16'h0001;
        end
      end
    endcase

    if (srst) begin
      s_next = '0;
      s_next.poll_en = POLL_EN_RST;
      s_next.gap = POLL_GAP_RST;
      s_next.half = MDC_HALF_RST;
      s_next.paddr = PADDR_RST;
      s_next.eng = E_IDLE;
      s_next.ps = P_NEXT;
      s_next.oe_n = 1'b1;
      s_next.mdio_o = 1'b1;
      s_next.m1 = 1'b1;
      s_next.m2 = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  // ****************
  // Outputs
  // ****************
  assign pready = psel && penable;
  assign prdata = s_reg.prdata;
  assign pslverr = s_reg.slverr && psel && penable;
  assign mdc = s_reg.mdc;
  assign mdio_o = s_reg.mdio_o;
  assign mdio_oe_n = s_reg.oe_n;
  assign mac_status = s_reg.stat;
endmodule
`default_nettype wire

//--- tb/mdmap_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdmap_phy_model (
  // Link from the master
  input wire logic mdc,
  input wire logic mdio_oe_n,
  input wire logic line,
  // Drive towards the shared line
  output logic drv_en,
  output logic drv_val
);
  logic [15:0] mem [0:1023];
  logic [13:0] hdr;
  logic [15:0] sh;
  int n;
  // ****************
  // Register contents, indexed {device, register}
  // ****************
  initial begin
    foreach (mem[i]) mem[i] = 16'h0;
    mem[0] = 16'hFFFF;
    mem[32] = 16'h2100;
    mem[33] = 16'h0004;
    mem[64] = 16'h1000;
    mem[65] = 16'h0004;
    mem[96] = 16'h1000;
    mem[97] = 16'h0024;
    mem[100] = 16'h0101;
    mem[101] = 16'h0101;
    mem[112] = 16'h0001;
    drv_en = 1'b0;
    drv_val = 1'b0;
    hdr = 14'h0;
    sh = 16'h0;
    n = 0;
  end
  // ****************
  // Frame decode
  // ****************
  always @(negedge mdio_oe_n) n = 0;
  always @(posedge mdc) begin
    if (n < 46) hdr = {hdr[12:0], line};
    else sh = {sh[14:0], line};
    if (n == 63 && hdr[13:10] == 4'b0101) mem[hdr[9:0]] = sh;
    n++;
  end
  // Turnaround low, then the word MSB first; released otherwise, so the pull-up shows
  always @(negedge mdc) begin
    drv_en = hdr[13:10] == 4'b0110 && n >= 47 && n <= 63;
    drv_val = (n >= 48 && n <= 63) ? mem[hdr[9:0]][63 - n] : 1'b0;
  end
endmodule
`default_nettype wire

//--- tb/mdmap_master_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mdmap_master_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Link and status
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe_n,
  input wire mdmap_pkg::mdmap_stat_type [5:0] mac_status
);
  import mdmap_pkg::*;
  logic mdc_reg, oe_reg, last_reg, rd_reg, rise;
  logic [6:0] bitc_reg;
  assign rise = mdc && !mdc_reg;
  // ****************
  // Bit counter, restarted when the master takes the line
  // ****************
  always_ff @(posedge clk) begin
    if (srst) begin
      mdc_reg <= 1'b0;
      oe_reg <= 1'b1;
      last_reg <= 1'b1;
      rd_reg <= 1'b0;
      bitc_reg <= 7'h00;
    end else begin
      mdc_reg <= mdc;
      oe_reg <= mdio_oe_n;
      if (oe_reg && !mdio_oe_n) bitc_reg <= 7'h00;
      else if (rise) bitc_reg <= bitc_reg + 7'h01;
      if (rise) last_reg <= mdio_o;
      if (rise && bitc_reg == 7'h22) rd_reg <= mdio_o;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence bit_at(logic [6:0] k);
    rise && bitc_reg == k;
  endsequence
  // ****************
  // Checks
  // ****************
  pready_follow_a: assert property (pready == (psel && penable))
    else $error("pready not zero wait");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h1C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  reset_idle_a: assert property ($fell(srst) |-> !mdc && mdio_o && mdio_oe_n && mac_status == '0)
    else $error("outputs not idle after reset");
  preamble_ones_a: assert property (rise && bitc_reg < 7'h20 |-> mdio_o)
    else $error("preamble bit low");
  start_code_a: assert property (bit_at(7'h21) |-> mdio_o && !last_reg)
    else $error("bad start code");
  kind_code_a: assert property (bit_at(7'h23) |-> mdio_o != last_reg)
    else $error("bad access kind");
  header_driven_a: assert property (rise && bitc_reg < 7'h2E |-> !mdio_oe_n)
    else $error("header not driven");
  write_turn_a: assert property (bit_at(7'h2F) ##0 !rd_reg |-> !mdio_o && last_reg)
    else $error("bad write turnaround");
  read_release_a: assert property (rise && rd_reg && bitc_reg >= 7'h2E |-> mdio_oe_n)
    else $error("line not released on read");
  frame_len_a: assert property (rise |-> bitc_reg < 7'h40)
    else $error("frame longer than 64 bits");
endmodule
bind mdmap_master mdmap_master_assertions i_mdmap_master_assertions (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .mdc(mdc),
  .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mac_status(mac_status));
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mdmap_pkg::*;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, mdc, mdio_o, mdio_oe_n, drv_en, drv_val, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  mdmap_stat_type [5:0] mac_status;
  int n_errors, checks_done, n;
  // Released line sits at its pull-up level
  wire mdio_line = !mdio_oe_n ? mdio_o : (drv_en ? drv_val : 1'b1);
  mdmap_master #(.GAP_UNIT(16'h0001)) i_mdmap_master (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mdc(mdc), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n), .mdio_i(mdio_line), .mac_status(mac_status));
  mdmap_phy_model i_mdmap_phy_model (.mdc(mdc), .mdio_oe_n(mdio_oe_n), .line(mdio_line), .drv_en(drv_en),
    .drv_val(drv_val));
  // ****************
  // Bus and check tasks
  // ****************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts status reads until the command clears
  task automatic wait_idle;
    n = 0;
    q = 32'h0000_8000;
    while (q[15] !== 1'b0) begin
      apb(1'b0, OFF_CMD, 32'h0);
      n++;
    end
  endtask
  task automatic half_time;
    @(posedge mdc);
    n = 0;
    @(negedge clk);
    while (mdc) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    results();
  end
  // ****************
  // Test sequence
  // ****************
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {4'b1000, 8'h00, 32'h0};
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, OFF_POLL, 32'h0);
    chk(q, 32'h0000_103F);
    apb(1'b0, OFF_SPEED, 32'h0);
    chk(q, 32'h0000_0004);
    apb(1'b0, OFF_PADDR, 32'h0);
    chk(q, 32'h0A41_8820);
    apb(1'b0, 8'h20, 32'h0);
    chk({q[30:0], err}, 32'h0000_0001);
    half_time();
    chk(32'(n), 32'h0000_0004);
    apb(1'b1, OFF_PADDR, 32'h0641_8820);
    repeat (20000) @(posedge clk);
    chk(32'(mac_status[0] & 8'h81), 32'h0000_0080);
    chk(32'(mac_status[1]), 32'h0000_003B);
    chk(32'(mac_status[2] & 8'h81), 32'h0000_0000);
    chk(32'(mac_status[3] & 8'hCF), 32'h0000_004B);
    chk(32'(mac_status[5] & 8'hCF), 32'h0000_004B);
    apb(1'b0, OFF_STAT_LO, 32'h0);
    chk(32'(q[15:8]), 32'h0000_003B);
    apb(1'b1, OFF_POLL, 32'h0000_103D);
    apb(1'b1, OFF_STAT_LO, 32'h0000_5500);
    repeat (6000) @(posedge clk);
    chk(32'(mac_status[1]), 32'h0000_0055);
    chk(32'(mac_status[3] & 8'hCF), 32'h0000_004B);
    wait_idle();
    apb(1'b1, OFF_WDATA, 32'h0000_BEEF);
    apb(1'b1, OFF_CMD, 32'h0000_04E3);
    apb(1'b1, OFF_CMD, 32'h0000_08E3);
    apb(1'b0, OFF_CMD, 32'h0);
    chk(32'(q[15]), 32'h0000_0001);
    wait_idle();
    // Worst case: one poll frame just launched, then the command frame, three cycles per status read
    chk(32'(n <= (2 * (64 * 2 * 4 + 4)) / 3 + 2), 32'h0000_0001);
    chk(q, 32'h0000_04E3);
    chk(32'(i_mdmap_phy_model.mem[227]), 32'h0000_BEEF);
    apb(1'b1, OFF_CMD, 32'h0000_08E3);
    wait_idle();
    apb(1'b0, OFF_RDATA, 32'h0);
    chk(q, 32'h0000_BEEF);
    apb(1'b1, OFF_SPEED, 32'h0);
    apb(1'b0, OFF_SPEED, 32'h0);
    chk(q, 32'h0000_0001);
    apb(1'b1, OFF_SPEED, 32'h0000_0002);
    half_time();
    half_time();
    chk(32'(n), 32'h0000_0002);
    results();
  end
endmodule
`default_nettype wire
